//--- src/tse_regs.svh
// Constants of the thermal sensor and configuration store: register offsets,
// field positions, reset values, memory regions and the serial bus address.
// Assumes a 32-bit Wishbone data path with byte addresses.
`ifndef TSE_REGS_SVH
`define TSE_REGS_SVH

`define TSE_TEMP_W 13
`define TSE_WB_AW 8

// Register byte offsets
`define TSE_REG_CFG 8'h00
`define TSE_REG_STATUS 8'h04
`define TSE_REG_TEMP 8'h08
`define TSE_REG_LIM_HIGH 8'h0c
`define TSE_REG_LIM_LOW 8'h10
`define TSE_REG_CRIT 8'h14
`define TSE_REG_CRIT_HYST 8'h18

// Field positions
`define TSE_CFG_EN_BIT 0
`define TSE_CFG_MODE_LSB 1
`define TSE_CFG_MODE_MSB 2
`define TSE_CFG_WP_BIT 8
`define TSE_ST_EVENT_BIT 0
`define TSE_ST_HIGH_BIT 1
`define TSE_ST_LOW_BIT 2
`define TSE_ST_CRIT_BIT 3

// Reset values and the refused mode code
`define TSE_RST_LIM_HIGH 13'h0fff
`define TSE_RST_LIM_LOW 13'h1000
`define TSE_RST_CRIT 13'h0550
`define TSE_RST_HYST 13'h0000
`define TSE_MODE_ILLEGAL 2'h3

// Store layout
`define TSE_MEM_AW 9
`define TSE_PROT_TOP 9'h180
`define TSE_RSVD_LO 9'h100
`define TSE_RSVD_HI 9'h140

// Upper six bits of the seven-bit serial address; the lowest bit picks the page
`define TSE_I2C_DEV 6'h28

`endif

//--- src/tse_pkg.sv
// Types of the thermal sensor and configuration store.
// Assumes tse_regs.svh is on the include path.
`include "tse_regs.svh"

package tse_pkg;

    typedef enum logic [1:0] {
        MODE_INTERRUPT  = 2'h0,
        MODE_COMPARATOR = 2'h1,
        MODE_CRIT_ONLY  = 2'h2
    } tse_alert_mode_t;

    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_DEV   = 9'h002,
        ST_DACK  = 9'h004,
        ST_WORD  = 9'h008,
        ST_WACK  = 9'h010,
        ST_WDATA = 9'h020,
        ST_DTACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_MACK  = 9'h100
    } tse_i2c_state_t;

    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        tse_i2c_state_t st;
        logic [2:0] bitcnt;
        logic [7:0] shreg;
        logic ack_on;
        logic rw;
        logic page;
        logic [7:0] addr;
        logic sda_drv;
        logic mem_we;
        logic [`TSE_MEM_AW-1:0] mem_waddr;
        logic [7:0] mem_wdata;
        logic [`TSE_TEMP_W-1:0] temp;
        logic [`TSE_TEMP_W-1:0] lim_high;
        logic [`TSE_TEMP_W-1:0] lim_low;
        logic [`TSE_TEMP_W-1:0] lim_crit;
        logic [`TSE_TEMP_W-1:0] hyst;
        logic alert_en;
        tse_alert_mode_t mode;
        logic wp;
        logic event_flag;
        logic win_prev;
        logic crit_flag;
        logic alert;
        logic wb_ack;
        logic [31:0] wb_dat;
    } tse_state_t;

endpackage

//--- src/tse_mem.sv
// Byte-wide storage of the configuration store, one write port, one read port.
// Read data come out of a register one clock after the address; no reset.
`timescale 1ns/100ps
`default_nettype none

module tse_mem #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

`default_nettype wire

//--- src/tse_top.sv
// Thermal sensor with alert output and a 512-byte configuration store on a
// two-wire serial slave; sensor registers sit on a classic Wishbone slave.
// Assumes temp_code/temp_valid come from a converter on sys_clk, and that
// scl/sda come straight from pins with an external pull-up on the wires.
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tse_regs.svh"

// Operation
// - Latch every new converter result into the temperature register.
// - Temperature register is readable at any time without preparation.
// - Open-drain active-low alert driven from programmed limits and options.
// - Only sensor logic drives the alert; the store never touches it.
// - Three alert behaviours: latched interrupt, comparator, critical only.
// - Interrupt alert holds until software writes one to event clear.
// - Comparator alert drops by itself when the condition goes away.
// - Critical limit comparison always behaves as a comparator.
// - Critical-only mode asserts only when temperature exceeds critical limit.
// - Critical-only alert holds until temperature is below limit minus hysteresis.
// - Store holds 512 bytes in four 128-byte regions.
// - Low two regions hold device and module parameters.
// - Bytes 100h to 13Fh read as zero; 140h to 17Fh hold manufacturing data.
// - Lowest 384 bytes carry factory-programmed presence-detect content; the store here has no preset image.
// - Top region 180h to 1FFh is free user storage.
// - Store is a serial slave timed by the serial clock, up to 1 MHz.
// - Reversible software protection blocks writes to bytes 0 to 383.
// - Top 128 bytes are never protected and always writable.
module tse_top
    import tse_pkg::*;
#(
    parameter logic [5:0] I2C_DEV = `TSE_I2C_DEV
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`TSE_WB_AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [`TSE_TEMP_W-1:0] temp_code,
    input wire logic temp_valid,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    output logic alert_o,
    output logic alert_oe_n
);

    tse_state_t q;
    tse_state_t d;

    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic [`TSE_MEM_AW-1:0] full_addr;
    logic [7:0] mem_rdata;
    logic [7:0] rd_byte;
    logic above_high;
    logic below_low;
    logic win_out;
    logic above_crit;
    logic below_rel;
    logic signed [`TSE_TEMP_W:0] crit_rel;
    logic wb_access;

    function automatic logic is_reserved(input logic [`TSE_MEM_AW-1:0] a);
        is_reserved = (a >= `TSE_RSVD_LO) && (a < `TSE_RSVD_HI);
    endfunction

    function automatic logic is_protected(input logic [`TSE_MEM_AW-1:0] a, input logic wp);
        is_protected = wp && (a < `TSE_PROT_TOP);
    endfunction

    function automatic logic [31:0] wmerge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] sel
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        wmerge = r;
    endfunction

    // Edges are taken from the second and third stages only
    assign scl_rise = q.scl_s2 & ~q.scl_s3;
    assign scl_fall = ~q.scl_s2 & q.scl_s3;
    assign i2c_start = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
    assign i2c_stop = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
    assign full_addr = {q.page, q.addr};
    assign rd_byte = is_reserved(full_addr) ? 8'h00 : mem_rdata;

    // Storage has no reset: the factory image must be loaded over the serial
    // bus with protection cleared before the part is used.
    tse_mem #(
        .AW(`TSE_MEM_AW),
        .DW(8)
    ) u_mem (
        .clk(sys_clk),
        .we(q.mem_we),
        .waddr(q.mem_waddr),
        .wdata(q.mem_wdata),
        .raddr(full_addr),
        .rdata(mem_rdata)
    );

    assign above_high = $signed(q.temp) > $signed(q.lim_high);
    assign below_low = $signed(q.temp) < $signed(q.lim_low);
    assign win_out = above_high | below_low;
    assign above_crit = $signed(q.temp) > $signed(q.lim_crit);
    assign crit_rel = $signed({q.lim_crit[`TSE_TEMP_W-1], q.lim_crit}) - $signed({1'b0, q.hyst});
    assign below_rel = $signed({q.temp[`TSE_TEMP_W-1], q.temp}) < crit_rel;
    assign wb_access = wb_cyc_i & wb_stb_i & ~q.wb_ack;

    always_comb begin
        logic [7:0] byte_in;
        logic [31:0] rd_val;
        logic [31:0] wm;
        logic evt_clr;
        byte_in = {q.shreg[6:0], q.sda_s2};
        rd_val = 32'h0000_0000;
        wm = 32'h0000_0000;
        evt_clr = 1'b0;
        d = q;
        d.mem_we = 1'b0;

        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        d.scl_s3 = q.scl_s2;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.sda_s3 = q.sda_s2;

        if (temp_valid) begin
            d.temp = temp_code;
        end

        // Register read view, shared by reads and by byte-lane merging
        unique case (wb_adr_i)
            `TSE_REG_CFG: begin
                rd_val[`TSE_CFG_EN_BIT] = q.alert_en;
                rd_val[`TSE_CFG_MODE_MSB:`TSE_CFG_MODE_LSB] = q.mode;
                rd_val[`TSE_CFG_WP_BIT] = q.wp;
            end
            `TSE_REG_STATUS: begin
                rd_val[`TSE_ST_EVENT_BIT] = q.event_flag;
                rd_val[`TSE_ST_HIGH_BIT] = above_high;
                rd_val[`TSE_ST_LOW_BIT] = below_low;
                rd_val[`TSE_ST_CRIT_BIT] = q.crit_flag;
            end
            `TSE_REG_TEMP: rd_val[`TSE_TEMP_W-1:0] = q.temp;
            `TSE_REG_LIM_HIGH: rd_val[`TSE_TEMP_W-1:0] = q.lim_high;
            `TSE_REG_LIM_LOW: rd_val[`TSE_TEMP_W-1:0] = q.lim_low;
            `TSE_REG_CRIT: rd_val[`TSE_TEMP_W-1:0] = q.lim_crit;
            `TSE_REG_CRIT_HYST: rd_val[`TSE_TEMP_W-1:0] = q.hyst;
            default: rd_val = 32'h0000_0000;
        endcase
        wm = wmerge(rd_val, wb_dat_i, wb_sel_i);

        d.wb_ack = wb_access;
        if (wb_access) begin
            d.wb_dat = rd_val;
            if (wb_we_i) begin
                unique case (wb_adr_i)
                    `TSE_REG_CFG: begin
                        d.alert_en = wm[`TSE_CFG_EN_BIT];
                        // The unused fourth code is refused; the mode stays
                        if (wm[`TSE_CFG_MODE_MSB:`TSE_CFG_MODE_LSB] != `TSE_MODE_ILLEGAL) begin
                            d.mode = tse_alert_mode_t'(wm[`TSE_CFG_MODE_MSB:`TSE_CFG_MODE_LSB]);
                        end
                        d.wp = wm[`TSE_CFG_WP_BIT];
                    end
                    `TSE_REG_STATUS: evt_clr = wb_sel_i[0] & wb_dat_i[`TSE_ST_EVENT_BIT];
                    `TSE_REG_LIM_HIGH: d.lim_high = wm[`TSE_TEMP_W-1:0];
                    `TSE_REG_LIM_LOW: d.lim_low = wm[`TSE_TEMP_W-1:0];
                    `TSE_REG_CRIT: d.lim_crit = wm[`TSE_TEMP_W-1:0];
                    `TSE_REG_CRIT_HYST: d.hyst = wm[`TSE_TEMP_W-1:0];
                    default: ;
                endcase
            end
        end

        // Alert evaluation
        d.win_prev = win_out;
        // A new excursion in the cycle of a clear keeps the flag set
        d.event_flag = (win_out & ~q.win_prev) | (q.event_flag & ~evt_clr);
        if (above_crit) begin
            d.crit_flag = 1'b1;
        end else if (below_rel) begin
            d.crit_flag = 1'b0;
        end
        unique case (q.mode)
            MODE_INTERRUPT: d.alert = q.alert_en & (q.event_flag | q.crit_flag);
            MODE_COMPARATOR: d.alert = q.alert_en & (win_out | q.crit_flag);
            MODE_CRIT_ONLY: d.alert = q.alert_en & q.crit_flag;
            default: d.alert = 1'b0;
        endcase

        // Serial slave, stepped by serial clock edges and by start and stop conditions
        if (i2c_start) begin
            d.st = ST_DEV;
            d.bitcnt = 3'h0;
            d.sda_drv = 1'b0;
            d.ack_on = 1'b0;
        end else if (i2c_stop) begin
            d.st = ST_IDLE;
            d.sda_drv = 1'b0;
            d.ack_on = 1'b0;
        end else if (scl_rise) begin
            unique case (q.st)
                ST_DEV, ST_WORD, ST_WDATA: begin
                    d.shreg = byte_in;
                    d.bitcnt = q.bitcnt + 3'h1;
                    if (q.bitcnt == 3'h7) begin
                        if (q.st == ST_DEV) begin
                            if (byte_in[7:2] == I2C_DEV) begin
                                d.page = byte_in[1];
                                d.rw = byte_in[0];
                                d.st = ST_DACK;
                            end else begin
                                d.st = ST_IDLE;
                            end
                        end else if (q.st == ST_WORD) begin
                            d.addr = byte_in;
                            d.st = ST_WACK;
                        end else begin
                            // Protected or reserved bytes keep their value, yet are acknowledged
                            d.mem_we = ~is_protected(full_addr, q.wp) & ~is_reserved(full_addr);
                            d.mem_waddr = full_addr;
                            d.mem_wdata = byte_in;
                            d.addr = q.addr + 8'h01;
                            d.st = ST_DTACK;
                        end
                    end
                end
                ST_RDATA: begin
                    d.bitcnt = q.bitcnt + 3'h1;
                    if (q.bitcnt == 3'h7) begin
                        d.st = ST_MACK;
                        d.ack_on = 1'b0;
                    end
                end
                ST_MACK: begin
                    if (!q.ack_on) begin
                        if (q.sda_s2) begin
                            d.st = ST_IDLE;
                        end else begin
                            d.ack_on = 1'b1;
                            d.addr = q.addr + 8'h01;
                        end
                    end
                end
                default: ;
            endcase
        end else if (scl_fall) begin
            unique case (q.st)
                ST_DACK, ST_WACK, ST_DTACK: begin
                    if (!q.ack_on) begin
                        d.ack_on = 1'b1;
                        d.sda_drv = 1'b1;
                    end else begin
                        d.ack_on = 1'b0;
                        d.sda_drv = 1'b0;
                        d.bitcnt = 3'h0;
                        if (q.st == ST_DACK && q.rw) begin
                            d.st = ST_RDATA;
                            d.shreg = rd_byte;
                            d.sda_drv = ~rd_byte[7];
                        end else if (q.st == ST_DACK) begin
                            d.st = ST_WORD;
                        end else begin
                            d.st = ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    d.shreg = {q.shreg[6:0], 1'b0};
                    d.sda_drv = ~q.shreg[6];
                end
                ST_MACK: begin
                    if (!q.ack_on) begin
                        d.sda_drv = 1'b0;
                    end else begin
                        d.ack_on = 1'b0;
                        d.bitcnt = 3'h0;
                        d.st = ST_RDATA;
                        d.shreg = rd_byte;
                        d.sda_drv = ~rd_byte[7];
                    end
                end
                default: ;
            endcase
        end

        if (!nrst) begin
            d = '0;
            d.scl_s1 = 1'b1;
            d.scl_s2 = 1'b1;
            d.scl_s3 = 1'b1;
            d.sda_s1 = 1'b1;
            d.sda_s2 = 1'b1;
            d.sda_s3 = 1'b1;
            d.st = ST_IDLE;
            d.mode = MODE_INTERRUPT;
            d.lim_high = `TSE_RST_LIM_HIGH;
            d.lim_low = `TSE_RST_LIM_LOW;
            d.lim_crit = `TSE_RST_CRIT;
            d.hyst = `TSE_RST_HYST;
        end
    end

    always_ff @(posedge sys_clk) begin
        q <= d;
    end

    assign wb_ack_o = q.wb_ack;
    assign wb_dat_o = q.wb_dat;
    assign sda_o = 1'b0;
    assign sda_oe_n = ~q.sda_drv;
    // Only the sensor state feeds this pin
    assign alert_o = 1'b0;
    assign alert_oe_n = ~q.alert;

endmodule

`default_nettype wire

//--- verification/tse_top_sva.sv
// Checker of the sensor top: bus handshake, alert pin and serial data pin.
// Sees only top-level ports; bound into every tse_top instance.
`timescale 1ns/100ps
`default_nettype none
`include "tse_regs.svh"
module tse_top_sva
    import tse_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`TSE_WB_AW-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [`TSE_TEMP_W-1:0] temp_code,
    input wire logic temp_valid,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_oe_n,
    input wire logic alert_o,
    input wire logic alert_oe_n
);
    logic [3:0] quiet_q;
    logic [`TSE_TEMP_W-1:0] temp_q;
    // Cycles since the last cause that may move the alert pin
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            quiet_q <= 4'hf;
            temp_q <= '0;
        end else begin
            if (temp_valid || (wb_cyc_i && wb_stb_i && wb_we_i))
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hf)
                quiet_q <= quiet_q + 4'h1;
            if (temp_valid)
                temp_q <= temp_code;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
    sequence s_start; scl_i && $fell(sda_i); endsequence
    property p_ack; s_req |=> s_ans; endproperty
    property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_temp_rd;
        wb_ack_o && !wb_we_i && wb_adr_i == `TSE_REG_TEMP && !$past(temp_valid)
            |-> wb_dat_o == {19'h0, temp_q};
    endproperty
    property p_alert_low; !alert_oe_n |-> alert_o == 1'b0; endproperty
    property p_alert_set; $fell(alert_oe_n) |-> quiet_q <= 4'h3; endproperty
    property p_alert_clr;
        $rose(alert_oe_n) |-> $past(temp_valid, 2) || $past(temp_valid, 3)
            || $past(wb_ack_o) || $past(wb_ack_o, 2);
    endproperty
    property p_sda_chg; $changed(sda_oe_n) |-> !scl_i; endproperty
    property p_sda_addr; s_start |-> ##4 sda_oe_n [*8]; endproperty
    a_ack: assert property (p_ack) else $error("ack is not one pulse");
    a_ack_src: assert property (p_ack_src) else $error("ack without request");
    a_temp_rd: assert property (p_temp_rd) else $error("stale temperature");
    a_alert_low: assert property (p_alert_low) else $error("alert not low");
    a_alert_set: assert property (p_alert_set) else $error("alert set uncaused");
    a_alert_clr: assert property (p_alert_clr) else $error("alert clear uncaused");
    a_sda_chg: assert property (p_sda_chg) else $error("sda moved, scl high");
    a_sda_addr: assert property (p_sda_addr) else $error("sda driven in address");
endmodule
bind tse_top tse_top_sva chk (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .temp_code(temp_code), .temp_valid(temp_valid), .scl_i(scl_i),
    .sda_i(sda_i), .sda_oe_n(sda_oe_n), .alert_o(alert_o), .alert_oe_n(alert_oe_n));
`default_nettype wire

//--- verification/tse_i2c_host.sv
// Behavioural serial bus master standing in for the host controller.
// Assumes the bench ANDs sda_rel with the slave pull-down and a pull-up.
`timescale 1ns/100ps
`default_nettype none
module tse_i2c_host (
    output logic scl,
    output logic sda_rel,
    input wire logic sda_w,
    output logic [7:0] rx_data,
    output logic rx_ev
);
    localparam time Q = 200ns;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
        rx_data = 8'h00;
        rx_ev = 1'b0;
    end
    // Clock stands high between frames; data moves mid low phase
    task automatic bit_io(input logic b, output logic v);
        sda_rel = b;
        #Q scl = 1'b1;
        #Q v = sda_w;
        #Q scl = 1'b0;
        #Q;
    endtask
    // The odd delay keeps pin changes off the device clock edges
    task automatic start();
        #13 sda_rel = 1'b1;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask
    task automatic stop();
        sda_rel = 1'b0;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b1;
        #(2 * Q);
    endtask
    // Byte out returns the slave acknowledge; byte in ends with our ack or nack
    task automatic xfer(input logic [7:0] b, input logic rd, input logic nak);
        logic [7:0] v;
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(rd | b[i], v[i]);
        bit_io(rd ? nak : 1'b1, a);
        rx_data = rd ? v : {7'h00, a};
        rx_ev = ~rx_ev;
    endtask
endmodule
`default_nettype wire

//--- verification/test_tse_top.sv
// Self-checking bench of the sensor top: Wishbone registers, alert, store.
// Assumes the serial host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "tse_regs.svh"
module test_tse_top
    import tse_pkg::*;
;
    logic sys_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, temp_valid;
    logic sda_o, sda_oe_n, alert_o, alert_oe_n, scl, sda_rel, sda_w, rx_ev;
    logic [7:0] wb_adr_i, rx_data;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [12:0] temp_code, t;
    logic [31:0] exp_q[$];
    logic [7:0] i2c_q[$];
    logic [7:0] r[4];
    logic [39:0] rst_tab[8] = '{40'h0000000000, 40'h0400000000, 40'h0800000000,
        40'h0c00000fff, 40'h1000001000, 40'h1400000550, 40'h1800000000, 40'h1c00000000};
    int error_cnt = 0;
    int n_checks = 0;
    assign sda_w = sda_rel & (sda_oe_n | sda_o);
    tse_top dut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .temp_code(temp_code),
        .temp_valid(temp_valid), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .alert_o(alert_o), .alert_oe_n(alert_oe_n));
    tse_i2c_host host (.scl(scl), .sda_rel(sda_rel), .sda_w(sda_w), .rx_data(rx_data),
        .rx_ev(rx_ev));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic complete_run();
        // Expected results never consumed mean a missing answer
        if (exp_q.size() != 0 || i2c_q.size() != 0)
            error_cnt++;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Asserted means the pin is pulled low and the driven level is low
    task automatic chk_pin(input logic e);
        n_checks++;
        if (alert_oe_n !== ~e || (e && alert_o !== 1'b0)) begin
            error_cnt++;
            $display("CHECK FAILED alert expected %b seen %b", ~e, alert_oe_n);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (i >= 20) begin
            error_cnt++;
            complete_run();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask
    task automatic step(input logic [12:0] v, input logic e);
        @(posedge sys_clk);
        temp_code <= v;
        temp_valid <= 1'b1;
        @(posedge sys_clk);
        temp_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk_pin(e);
    endtask
    task automatic i2c_head(input logic [8:0] a);
        host.start();
        host.xfer({`TSE_I2C_DEV, a[8], 1'b0}, 1'b0, 1'b0);
        host.xfer(a[7:0], 1'b0, 1'b0);
    endtask
    task automatic i2c_wr(input logic [8:0] a, input logic [7:0] d0, input logic [7:0] d1);
        i2c_q = {i2c_q, 8'h00, 8'h00, 8'h00, 8'h00};
        i2c_head(a);
        host.xfer(d0, 1'b0, 1'b0);
        host.xfer(d1, 1'b0, 1'b0);
        host.stop();
    endtask
    task automatic i2c_rd(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1);
        i2c_q = {i2c_q, 8'h00, 8'h00, 8'h00, e0, e1};
        i2c_head(a);
        host.start();
        host.xfer({`TSE_I2C_DEV, a[8], 1'b1}, 1'b0, 1'b0);
        host.xfer(8'h00, 1'b1, 1'b0);
        host.xfer(8'h00, 1'b1, 1'b1);
        host.stop();
    endtask
    always @(posedge sys_clk) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
            chk_word("wb_dat_o", exp_q.pop_front(), wb_dat_o);
    end
    // Skips the time-zero settle of rx_ev
    always @(rx_ev) begin
        if (i2c_q.size() != 0)
            chk_word("serial byte", {24'h0, i2c_q.pop_front()}, {24'h0, rx_data});
    end
    initial begin
        {nrst, wb_cyc_i, wb_stb_i, wb_we_i, temp_valid} = 5'h00;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        temp_code = 13'h0000;
        void'($urandom(39));
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        foreach (rst_tab[k])
            rd(rst_tab[k][39:32], rst_tab[k][31:0]);
        t = 13'($urandom);
        step(t, 1'b0);
        t = 13'($urandom);
        step(t, 1'b0);
        rd(`TSE_REG_TEMP, {19'h0, t});
        wb(1'b1, `TSE_REG_LIM_HIGH, 32'h100);
        wb(1'b1, `TSE_REG_LIM_LOW, 32'h0);
        wb(1'b1, `TSE_REG_CRIT, 32'h400);
        wb(1'b1, `TSE_REG_CRIT_HYST, 32'h40);
        step(13'h080, 1'b0);
        wb(1'b1, `TSE_REG_STATUS, 32'h1);
        wb(1'b1, `TSE_REG_CFG, 32'h1);
        step(13'h200, 1'b1);
        step(13'h080, 1'b1);
        rd(`TSE_REG_STATUS, 32'h1);
        wb(1'b1, `TSE_REG_STATUS, 32'h1);
        step(13'h080, 1'b0);
        wb(1'b1, `TSE_REG_CFG, 32'h3);
        step(13'h200, 1'b1);
        step(13'h080, 1'b0);
        wb(1'b1, `TSE_REG_STATUS, 32'h1);
        wb(1'b1, `TSE_REG_LIM_HIGH, 32'h600);
        wb(1'b1, `TSE_REG_CFG, 32'h1);
        step(13'h500, 1'b1);
        step(13'h080, 1'b0);
        wb(1'b1, `TSE_REG_LIM_HIGH, 32'h100);
        wb(1'b1, `TSE_REG_CFG, 32'h5);
        step(13'h200, 1'b0);
        step(13'h400, 1'b0);
        step(13'h401, 1'b1);
        step(13'h3c0, 1'b1);
        step(13'h3bf, 1'b0);
        wb(1'b1, `TSE_REG_CFG, 32'h7);
        rd(`TSE_REG_CFG, 32'h5);
        step(13'h401, 1'b1);
        // Event still latched, above high and critical flags live
        rd(`TSE_REG_STATUS, 32'hb);
        step(13'h080, 1'b0);
        foreach (r[k])
            r[k] = 8'($urandom);
        i2c_wr(9'h17e, r[0], r[1]);
        i2c_wr(9'h13f, 8'h11, 8'h22);
        i2c_rd(9'h13f, 8'h00, 8'h22);
        i2c_wr(9'h180, r[2], r[3]);
        wb(1'b1, `TSE_REG_CFG, 32'h105);
        i2c_wr(9'h17f, 8'h55, 8'h66);
        i2c_rd(9'h17e, r[0], r[1]);
        i2c_rd(9'h180, 8'h66, r[3]);
        wb(1'b1, `TSE_REG_CFG, 32'h5);
        i2c_wr(9'h17e, 8'h77, 8'h88);
        i2c_rd(9'h17e, 8'h77, 8'h88);
        // Foreign device byte: no acknowledge, the pull-up reads high
        i2c_q.push_back(8'h01);
        host.start();
        host.xfer(8'h00, 1'b0, 1'b0);
        host.stop();
        chk_pin(1'b0);
        repeat (10) @(posedge sys_clk);
        complete_run();
    end
endmodule
`default_nettype wire
